/* common/fpec_params.svh */
`ifndef FPEC_PARAMS_SVH
`define FPEC_PARAMS_SVH
// Register byte offsets on the register bus.
`define FPEC_OFS_CTRL1     8'h00
`define FPEC_OFS_CTRL2     8'h04
`define FPEC_OFS_PROT      8'h08
`define FPEC_OFS_FLAG      8'h0C
`define FPEC_OFS_IEN       8'h10
`define FPEC_OFS_FCLR      8'h14
`define FPEC_OFS_PC        8'h18
// Key that must sit in the upper half of a protected write.
`define FPEC_KEY           16'h5A5A
// Operation select codes.
`define FPEC_MODE_READ     2'h0
`define FPEC_MODE_NONBLANK_TARGET_ERROR     2'h1
`define FPEC_MODE_ERASE    2'h2
// Primary control word field positions.
`define FPEC_CR1_BUSY_BIT  4
// Secondary control word fields and reset value.
`define FPEC_CR2_CACHE_BIT 3
`define FPEC_CR2_FETCH_BIT 4
`define FPEC_CR2_RESET     5'h18
// Error flag bit positions.
`define FPEC_ERR_LOCK_BIT  0
`define FPEC_ERR_PC_BIT    1
`define FPEC_ERR_NONBLANK_TARGET_ERROR_BIT  2
// Array geometry: 64 KiB, 512-byte pages, 8 pages per protection bit.
`define FPEC_ARRAY_BYTES   65536
`define FPEC_PAGE_BYTES    512
// Busy time of an erase and of a program step, in bus clock cycles.
`define FPEC_ERASE_CYCLES  16'h0200
`define FPEC_NONBLANK_TARGET_ERROR_CYCLES   16'h0010
`endif

/* common/fpec_pkg.sv */
package fpec_pkg;
  typedef enum logic [1:0] {
    FPEC_IDLE  = 2'h0,
    FPEC_CHECK = 2'h1,
    FPEC_RUN   = 2'h3
  } fpec_state_type;
  typedef logic [15:0] fpec_addr_type;
endpackage : fpec_pkg

/* logic/fpec_array.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fpec_params.svh"
// Flash array model in flip-flops: 32-bit word read port, programs clear bits only.
module fpec_array
  import fpec_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_rstn,
  input  wire fpec_addr_type i_raddr,
  output logic [31:0]        o_rdata,
  input  wire logic          i_nonblank_target_error,
  input  wire fpec_addr_type i_paddr,
  input  wire logic [31:0]   i_pdata,
  input  wire logic [3:0]    i_pstrb,
  input  wire logic          i_erase,
  input  wire logic [6:0]    i_epage
);
  typedef struct packed {
    logic [`FPEC_ARRAY_BYTES-1:0][7:0] mem;
  } fpec_arr_type;
  fpec_arr_type st_ff;
  fpec_arr_type nxt_st;

  // Read word gathers four bytes at the given aligned word address.
  always_comb begin
    o_rdata = {st_ff.mem[{i_raddr[15:2], 2'h3}], st_ff.mem[{i_raddr[15:2], 2'h2}],
               st_ff.mem[{i_raddr[15:2], 2'h1}], st_ff.mem[{i_raddr[15:2], 2'h0}]};
  end

  // Erase sets a page to all ones; program ANDs in new data.
  always_comb begin
    nxt_st = st_ff;
    if (i_erase) begin
      for (int i = 0; i < `FPEC_PAGE_BYTES; i++) begin
        nxt_st.mem[{i_epage, i[8:0]}] = 8'hFF;
      end
    end
    if (i_nonblank_target_error) begin
      for (int b = 0; b < 4; b++) begin
        if (i_pstrb[b]) begin
          nxt_st.mem[{i_paddr[15:2], b[1:0]}] =
            st_ff.mem[{i_paddr[15:2], b[1:0]}] & i_pdata[8*b +: 8];
        end
      end
    end
  end

  // Reset loads the array blank, all ones.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_ff <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : fpec_array
`default_nettype wire

/* logic/fpec_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fpec_params.svh"
module fpec_ctrl
  import fpec_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // AXI4-Lite register slave.
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Direct memory port of the flash window.
  input  wire logic        i_mvalid,
  input  wire logic        i_mwrite,
  input  wire logic [15:0] i_maddr,
  input  wire logic [1:0]  i_msize,
  input  wire logic [31:0] i_mwdata,
  output logic             o_mready,
  output logic [31:0]      o_mrdata,
  output logic             o_hardfault,
  output logic             o_irq,
  output logic             o_busy
);
  typedef struct packed {
    logic [1:0]     mode;
    logic [2:0]     wait_cfg;
    logic           cache_en;
    logic           fetch_en;
    logic [15:0]    prot;
    logic [2:0]     flag;
    logic [2:0]     ien;
    logic [15:0]    pc_addr;
    logic           pc_in_flash;
    fpec_state_type state;
    logic           is_erase;
    logic [15:0]    op_addr;
    logic [31:0]    op_data;
    logic [3:0]     op_strb;
    logic [15:0]    cnt;
    logic [2:0]     wcnt;
    logic           aw_got;
    logic           w_got;
    logic [7:0]     awaddr;
    logic [31:0]    wdata;
    logic           bvalid;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [1:0]     rresp;
    logic [31:0]    mrdata;
    logic           hardfault;
  } fpec_st_type;
  fpec_st_type st_ff;
  fpec_st_type nxt_st;

  logic [31:0] arr_rdata;
  logic        arr_nonblank_target_error;
  logic        arr_erase;

  // Byte lanes touched by an access of the given size and offset.
  function automatic logic [3:0] lane_mask(input logic [1:0] sz,
                                           input logic [1:0] ofs);
    unique case (sz)
      2'h0:    lane_mask = 4'h1 << ofs;
      2'h1:    lane_mask = ofs[1] ? 4'hC : 4'h3;
      default: lane_mask = 4'hF;
    endcase
  endfunction : lane_mask

  // True when the address is aligned to the access width.
  function automatic logic aligned(input logic [1:0] sz,
                                   input logic [1:0] ofs);
    unique case (sz)
      2'h0:    aligned = 1'b1;
      2'h1:    aligned = !ofs[0];
      2'h2:    aligned = (ofs == 2'h0);
      default: aligned = 1'b0;
    endcase
  endfunction : aligned

  // Page index from a byte address.
  function automatic logic [6:0] page_of(input logic [15:0] a);
    page_of = a[15:9];
  endfunction : page_of

  fpec_array u_array (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_raddr (st_ff.state == FPEC_IDLE ? i_maddr : st_ff.op_addr),
    .o_rdata (arr_rdata),
    .i_nonblank_target_error  (arr_nonblank_target_error),
    .i_paddr (st_ff.op_addr),
    .i_pdata (st_ff.op_data),
    .i_pstrb (st_ff.op_strb),
    .i_erase (arr_erase),
    .i_epage (page_of(st_ff.op_addr))
  );

  // Array commits only at the end of a successful run.
  assign arr_nonblank_target_error  = (st_ff.state == FPEC_RUN) && (st_ff.cnt == 16'h0001)
                     && !st_ff.is_erase;
  assign arr_erase = (st_ff.state == FPEC_RUN) && (st_ff.cnt == 16'h0001)
                     && st_ff.is_erase;

  // Handshake outputs and registered data outputs.
  assign o_awready   = !st_ff.aw_got && !st_ff.bvalid;
  assign o_wready    = !st_ff.w_got && !st_ff.bvalid;
  assign o_bvalid    = st_ff.bvalid;
  assign o_bresp     = 2'h0;
  assign o_arready   = !st_ff.rvalid;
  assign o_rvalid    = st_ff.rvalid;
  assign o_rdata     = st_ff.rdata;
  assign o_rresp     = st_ff.rresp;
  assign o_mrdata    = st_ff.mrdata;
  assign o_hardfault = st_ff.hardfault;
  assign o_busy      = (st_ff.state != FPEC_IDLE);
  assign o_irq       = |(st_ff.flag & st_ff.ien);
  assign o_mready    = i_mvalid && (st_ff.state == FPEC_IDLE)
                       && (i_mwrite || !aligned(i_msize, i_maddr[1:0])
                           || st_ff.wcnt == st_ff.wait_cfg);

  // Whole next-state computation.
  always_comb begin
    logic        keyok;
    logic        wr_fire;
    logic [31:0] w;
    logic [3:0]  m;
    logic        lock_bad;
    logic        pc_bad;
    logic        nonblank;
    logic [2:0]  fset;
    keyok    = 1'b0;
    wr_fire  = 1'b0;
    w        = 32'h0000_0000;
    m        = 4'h0;
    lock_bad = 1'b0;
    pc_bad   = 1'b0;
    nonblank = 1'b0;
    fset     = 3'h0;
    nxt_st   = st_ff;
    nxt_st.hardfault = 1'b0;

    // Register write channel; address and data may come in either order.
    if (i_awvalid && o_awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = i_wdata;
    end
    if (st_ff.aw_got && st_ff.w_got) begin
      wr_fire       = 1'b1;
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
    end
    if (st_ff.bvalid && i_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    w     = st_ff.wdata;
    keyok = (w[31:16] == `FPEC_KEY);
    if (wr_fire) begin
      unique case (st_ff.awaddr)
        `FPEC_OFS_CTRL1: if (keyok) nxt_st.mode = w[1:0];
        `FPEC_OFS_CTRL2: if (keyok) begin
          nxt_st.wait_cfg = w[2:0];
          nxt_st.cache_en = w[`FPEC_CR2_CACHE_BIT];
          nxt_st.fetch_en = w[`FPEC_CR2_FETCH_BIT];
        end
        `FPEC_OFS_PROT:  if (keyok) nxt_st.prot = w[15:0];
        `FPEC_OFS_IEN:   nxt_st.ien = w[2:0];
        `FPEC_OFS_FCLR:  nxt_st.flag = st_ff.flag & w[2:0];
        `FPEC_OFS_PC: begin
          nxt_st.pc_addr     = w[15:0];
          nxt_st.pc_in_flash = w[16];
        end
        default: ;
      endcase
    end

    // Register read channel; unmapped offsets read zero with DECERR.
    if (st_ff.rvalid && i_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = 2'h0;
      unique case (i_araddr)
        `FPEC_OFS_CTRL1: nxt_st.rdata = {27'h0, o_busy, 2'h0, st_ff.mode};
        `FPEC_OFS_CTRL2: nxt_st.rdata = {27'h0, st_ff.fetch_en,
                                          st_ff.cache_en, st_ff.wait_cfg};
        `FPEC_OFS_PROT:  nxt_st.rdata = {16'h0, st_ff.prot};
        `FPEC_OFS_FLAG:  nxt_st.rdata = {29'h0, st_ff.flag};
        `FPEC_OFS_IEN:   nxt_st.rdata = {29'h0, st_ff.ien};
        `FPEC_OFS_FCLR:  nxt_st.rdata = 32'h0000_0007;
        `FPEC_OFS_PC:    nxt_st.rdata = {15'h0, st_ff.pc_in_flash,
                                          st_ff.pc_addr};
        default: begin
          nxt_st.rdata = 32'h0000_0000;
          nxt_st.rresp = 2'h3;
        end
      endcase
    end

    // Read wait counter runs while any read, aligned or not, is pending in idle.
    if (i_mvalid && !i_mwrite && st_ff.state == FPEC_IDLE
        && st_ff.wcnt != st_ff.wait_cfg) begin
      nxt_st.wcnt = st_ff.wcnt + 3'h1;
    end else begin
      nxt_st.wcnt = 3'h0;
    end

    // Memory port accesses: fault, read, or start an operation.
    if (o_mready) begin
      m = lane_mask(i_msize, i_maddr[1:0]);
      if (!aligned(i_msize, i_maddr[1:0])) begin
        nxt_st.hardfault = 1'b1;
      end else if (!i_mwrite) begin
        nxt_st.mrdata = arr_rdata;
      end else if (st_ff.mode == `FPEC_MODE_ERASE
                   || st_ff.mode == `FPEC_MODE_NONBLANK_TARGET_ERROR) begin
        nxt_st.state    = FPEC_CHECK;
        nxt_st.is_erase = (st_ff.mode == `FPEC_MODE_ERASE);
        nxt_st.op_addr  = i_maddr;
        nxt_st.op_data  = i_mwdata;
        nxt_st.op_strb  = m;
      end
    end

    // Check phase: protection, executing page, blank target.
    lock_bad = !st_ff.prot[st_ff.op_addr[15:12]];
    pc_bad   = st_ff.pc_in_flash
               && page_of(st_ff.pc_addr) == page_of(st_ff.op_addr);
    for (int b = 0; b < 4; b++) begin
      if (st_ff.op_strb[b] && arr_rdata[8*b +: 8] != 8'hFF) begin
        nonblank = 1'b1;
      end
    end
    unique case (st_ff.state)
      FPEC_IDLE: ;
      FPEC_CHECK: begin
        if (lock_bad) begin
          fset[`FPEC_ERR_LOCK_BIT] = 1'b1;
        end else if (pc_bad) begin
          fset[`FPEC_ERR_PC_BIT] = 1'b1;
        end else if (!st_ff.is_erase && nonblank) begin
          fset[`FPEC_ERR_NONBLANK_TARGET_ERROR_BIT] = 1'b1;
        end
        if (fset != 3'h0) begin
          nxt_st.state = FPEC_IDLE;
        end else begin
          nxt_st.state = FPEC_RUN;
          nxt_st.cnt   = st_ff.is_erase ? `FPEC_ERASE_CYCLES
                                        : `FPEC_NONBLANK_TARGET_ERROR_CYCLES;
        end
      end
      FPEC_RUN: begin
        nxt_st.cnt = st_ff.cnt - 16'h0001;
        if (st_ff.cnt == 16'h0001) begin
          nxt_st.state = FPEC_IDLE;
        end
      end
      default: nxt_st.state = FPEC_IDLE;
    endcase
    // A flag set in the same cycle as its clear survives.
    nxt_st.flag = nxt_st.flag | fset;
  end

  // State register with synchronous reset.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_ff          <= '0;
      st_ff.cache_en <= 1'b1;
      st_ff.fetch_en <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : fpec_ctrl
`default_nettype wire

/* testbench/fpec_ctrl_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// Watches bus answers, memory port takes and the busy status.
module fpec_ctrl_sva (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic        i_mvalid,
  input wire logic        o_mready,
  input wire logic [15:0] i_maddr,
  input wire logic [1:0]  i_msize,
  input wire logic        o_hardfault,
  input wire logic        o_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // A memory take whose address breaks the access width alignment.
  sequence seq_mis_take;
    i_mvalid && o_mready && ((i_msize == 2'h1 && i_maddr[0]) ||
      (i_msize == 2'h2 && i_maddr[1:0] != 2'h0));
  endsequence
  // An operation that passed its checks and went on running.
  sequence seq_run;
    $rose(o_busy) ##1 o_busy;
  endsequence
  chk_hf_cause: assert property (seq_mis_take |=> o_hardfault)
    else $error("no fault after misaligned take");
  chk_hf_source: assert property (o_hardfault |-> $past(o_mready))
    else $error("fault without a take");
  chk_run_length: assert property (seq_run |-> o_busy [*8])
    else $error("busy dropped too early");
  chk_busy_ends: assert property ($rose(o_busy) |-> ##[1:600] !o_busy)
    else $error("busy never cleared");
  chk_busy_no_take: assert property (o_busy |-> !o_mready)
    else $error("memory take while busy");
  chk_write_answer: assert property (i_awvalid && o_awready && i_wvalid &&
      o_wready |=> ##1 o_bvalid)
    else $error("write response missing");
  chk_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped");
  chk_bresp_okay: assert property (o_bvalid |-> o_bresp == 2'h0)
    else $error("write response not okay");
  chk_rvalid_hold: assert property (o_rvalid && !i_rready |=> o_rvalid)
    else $error("read response dropped");
endmodule : fpec_ctrl_sva
bind fpec_ctrl fpec_ctrl_sva fpec_ctrl_sva_inst (.i_clk, .i_rstn,
  .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_bready,
  .o_bresp, .o_rvalid, .i_rready, .i_mvalid, .o_mready, .i_maddr,
  .i_msize, .o_hardfault, .o_busy);
`default_nettype wire

/* testbench/fpec_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Processor side of the flash window: issues loads and stores.
module fpec_cpu_model (
  input  wire logic        i_clk,
  input  wire logic        i_mready,
  input  wire logic [31:0] i_mrdata,
  input  wire logic        i_hardfault,
  output var logic         o_mvalid,
  output var logic         o_mwrite,
  output logic      [15:0] o_maddr,
  output var logic  [1:0]  o_msize,
  output logic      [31:0] o_mwdata
);
  logic [15:0] req_addr = 16'h0000;
  logic [31:0] req_data = 32'h0000_0000;
  logic [47:0] idle_pat = 48'hA5A5_0F0F_3C3C;
  initial o_mvalid = 1'b0;
  initial o_mwrite = 1'b0;
  initial o_msize = 2'h0;
  // Idle address and data change every cycle, so nothing stale is seen.
  always @(posedge i_clk) idle_pat <= ~idle_pat;
  assign o_maddr = o_mvalid ? req_addr : idle_pat[47:32];
  assign o_mwdata = o_mvalid ? req_data : idle_pat[31:0];
  // One access, held until taken; returns data, fault and wait count.
  task automatic access(input logic w, input logic [15:0] a,
      input logic [1:0] s, input logic [31:0] d,
      output logic [31:0] rd, output logic hf, output int n);
    n = 0;
    req_addr <= a;
    req_data <= d;
    o_mwrite <= w;
    o_msize <= s;
    o_mvalid <= 1'b1;
    @(negedge i_clk);
    while (!i_mready) begin
      n++;
      @(negedge i_clk);
    end
    @(posedge i_clk);
    o_mvalid <= 1'b0;
    @(negedge i_clk);
    rd = i_mrdata;
    hf = i_hardfault;
  endtask : access
endmodule : fpec_cpu_model
`default_nettype wire

/* testbench/tb_fpec_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_fpec_ctrl;
  logic        i_clk = 1'b0, i_rstn = 1'b0;
  logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_arvalid = 1'b0;
  logic        i_bready = 1'b1, i_rready = 1'b1;
  logic [3:0]  i_wstrb = 4'hF;
  logic [31:0] i_wdata = 32'h0, o_rdata, o_mrdata, i_mwdata;
  logic [1:0]  o_bresp, o_rresp, i_msize;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic        i_mvalid, i_mwrite, o_mready, o_hardfault, o_irq, o_busy;
  logic [15:0] i_maddr, prot = 16'h0;
  logic [31:0] lfsr = 32'h1F9FB4F3, rd, x, mem [int];
  logic        hf, pc_on = 1'b0;
  int          n, mode = 0, flags = 0, ien = 0, pc_pg = 0;
  int          err_count = 0, n_checks = 0;
  always #5 i_clk = ~i_clk;
  fpec_ctrl fpec_ctrl_inst (.*);
  fpec_cpu_model fpec_cpu_model_inst (.i_clk, .i_mready(o_mready),
    .i_mrdata(o_mrdata), .i_hardfault(o_hardfault), .o_mvalid(i_mvalid),
    .o_mwrite(i_mwrite), .o_maddr(i_maddr), .o_msize(i_msize),
    .o_mwdata(i_mwdata));
  function automatic logic [31:0] ex(input int a);
    return mem.exists(a) ? mem[a] : 32'hFFFFFFFF;
  endfunction : ex
  // Next value of the stimulus shift register.
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Register write; the model follows the key and clear semantics.
  task automatic rw(input logic [7:0] a, input logic [31:0] v);
    logic ta = 1'b0, tw = 1'b0;
    i_awaddr <= a;
    i_wdata <= v;
    i_bready <= 1'b0;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge i_clk);
      ta |= i_awvalid && o_awready;
      tw |= i_wvalid && o_wready;
      @(posedge i_clk);
      if (ta) i_awvalid <= 1'b0;
      if (tw) i_wvalid <= 1'b0;
    end
    // Accept the response late so that it must be held.
    repeat (2) @(posedge i_clk);
    i_bready <= 1'b1;
    do @(negedge i_clk); while (!o_bvalid);
    @(posedge i_clk);
    if (v[31:16] == 16'h5A5A && a == 8'h00) mode = v[1:0];
    if (v[31:16] == 16'h5A5A && a == 8'h08) prot = v[15:0];
    if (a == 8'h10) ien = v;
    if (a == 8'h14) flags &= v;
    if (a == 8'h18) pc_on = v[16];
    if (a == 8'h18) pc_pg = v[15:0] / 512;
  endtask : rw
  // Register read compared under a mask.
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b0;
    do @(negedge i_clk); while (!o_arready);
    @(posedge i_clk);
    i_arvalid <= 1'b0;
    // Accept the read data one cycle late so that it must be held.
    @(posedge i_clk);
    i_rready <= 1'b1;
    do @(negedge i_clk); while (!o_rvalid);
    x = o_rdata;
    hf = o_rresp == 2'h3;
    @(posedge i_clk);
    chk(x & m, e);
  endtask : rchk
  task automatic mx(input logic w, input int a, s, input logic [31:0] d);
    fpec_cpu_model_inst.access(w, 16'(a), 2'(s), d, rd, hf, n);
    @(posedge i_clk);
  endtask : mx
  // One erase or program store, run through the model and compared.
  task automatic op(input int a, s, input logic [31:0] d);
    int pg = a / 512, i;
    logic [31:0] old = ex(a & -4), m;
    m = (s == 2) ? '1 : ((32'h1 << (8 << s)) - 1) << (8 * (a % 4));
    mx(1'b1, a, s, d);
    if (!prot[pg / 8]) flags |= 1;
    else if (pc_on && pc_pg == pg) flags |= 2;
    else if (mode == 2)
      for (i = 0; i < 512; i += 4) mem.delete(pg * 512 + i);
    else if ((old & m) != m) flags |= 4;
    else mem[a & -4] = old & (d | ~m);
    i = 0;
    do begin
      @(negedge i_clk);
      i++;
    end while (o_busy && i < 700);
    @(posedge i_clk);
    chk(o_busy, 0);
    rchk(8'h0C, 7, flags);
    chk(o_irq, |(flags & ien));
    mx(1'b0, a & -4, 2, 0);
    chk(rd, ex(a & -4));
  endtask : op
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // Hang guard, far beyond the expected run length.
  initial begin
    #200us;
    err_count++;
    report_and_stop();
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    mx(1'b0, 0, 2, 0);
    chk(rd, ex(0));
    rchk(8'h04, 32'h1F, 32'h18);
    rw(8'h04, 32'h5A5A0000);
    rw(8'h00, 32'h00000001);
    rchk(8'h00, 3, mode);
    rw(8'h00, 32'h5A5A0001);
    rchk(8'h00, 3, mode);
    rw(8'h10, 32'h7);
    op(0, 2, 32'h0);
    rw(8'h14, 32'hFFFFFFFF);
    rchk(8'h0C, 7, flags);
    rw(8'h14, 32'hFFFFFFFE);
    rchk(8'h0C, 7, flags);
    rw(8'h08, 32'h5A5A0001);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      op(4 + 2 * i, i % 3, lfsr);
      op(512 + 4 * i, 2, lfsr);
    end
    op(4, 0, 32'h0);
    rw(8'h14, 32'h0);
    mx(1'b0, 1, 1, 0);
    chk(hf, 1);
    mx(1'b0, 2, 2, 0);
    chk(hf, 1);
    mx(1'b0, 1, 0, 0);
    chk(hf, 0);
    rw(8'h18, 32'h00010010);
    rw(8'h00, 32'h5A5A0002);
    op(16, 0, 32'h0);
    rw(8'h18, 32'h0);
    op(16, 0, 32'h0);
    mx(1'b0, 512, 2, 0);
    chk(rd, ex(512));
    rw(8'h08, 32'h5A5A0000);
    op(520, 2, 32'h0);
    rw(8'h14, 32'h0);
    for (int w = 0; w < 3; w++) begin
      rw(8'h04, 32'h5A5A0000 | w);
      mx(1'b0, 512, 2, 0);
      chk(n, w);
    end
    rw(8'h04, 32'h5A5A0018);
    rw(8'h00, 32'h5A5A0000);
    // A store in read mode must start nothing and raise no flag.
    mx(1'b1, 524, 2, 0);
    rchk(8'h0C, 7, flags);
    mx(1'b0, 524, 2, 0);
    chk(rd, ex(524));
    rchk(8'h40, '1, 0);
    chk(hf, 1);
    report_and_stop();
  end
endmodule : tb_fpec_ctrl
`default_nettype wire
